// [gpio_port_pkg.sv]
// constants for the five-pin port with trace hand-over
package gpio_port_pkg;
  localparam int NUM_PINS = 5;
  localparam logic [31:0] BASE_ADDR = 32'h400C_0500;
  localparam logic [11:0] PIN_DATA_OFS = 12'h000;
  localparam logic [11:0] OUTPUT_ENABLE_CTL_OFS = 12'h004;
  localparam logic [11:0] FUNCTION_SELECT_OFS = 12'h008;
  localparam logic [11:0] OPEN_DRAIN_CTL_OFS = 12'h028;
  localparam logic [11:0] PULLUP_CTL_OFS = 12'h02C;
  localparam logic [11:0] INPUT_ENABLE_CTL_OFS = 12'h038;
  localparam logic [4:0] REG_RESET = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int TRACE_CLK_PIN = 0;
  localparam int TRACE_DATA_LSB = 1;
endpackage : gpio_port_pkg

// [gpio_pin_if.sv]
// per-pin configuration bundle between register file and pad mux
`timescale 1ns/10ps
`default_nettype none
interface gpio_pin_if;
  logic [4:0] data;
  logic [4:0] oe;
  logic [4:0] fsel;
  logic [4:0] od;
  logic [4:0] pu;
  logic [4:0] ie;
  logic [4:0] pin_in;
  logic [4:0] rd_in;
  modport regs (output data, oe, fsel, od, pu, ie, pin_in, input rd_in);
  modport mux (input data, oe, fsel, od, pu, ie, pin_in, output rd_in);
endinterface : gpio_pin_if
`default_nettype wire

// [gpio_pad_mux.sv]
// pad mux: gpio vs trace, push-pull vs open-drain
`timescale 1ns/10ps
`default_nettype none
module gpio_pad_mux (
  input wire logic aclk,
  input wire logic aresetn,
  gpio_pin_if.mux cfg,
  input wire logic trace_clock_out,
  input wire logic [3:0] trace_data,
  output logic [4:0] pad_out_ff,
  output logic [4:0] pad_oe_ff,
  output logic [4:0] pad_pullup_ff
);
  logic [4:0] alt_val;
  logic [4:0] nxt_out;
  logic [4:0] nxt_oe;
  // trace_data[0] doubles as single_wire_viewer_out
  assign alt_val = {trace_data, trace_clock_out};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_pin
      always_comb begin
        if (cfg.fsel[g]) begin
          nxt_out[g] = alt_val[g];
          nxt_oe[g] = 1'b1;
        end else if (cfg.od[g]) begin
          nxt_out[g] = 1'b0;
          nxt_oe[g] = cfg.oe[g] & ~cfg.data[g];
        end else begin
          nxt_out[g] = cfg.data[g];
          nxt_oe[g] = cfg.oe[g];
        end
      end
      // disabled input reads zero
      assign cfg.rd_in[g] = cfg.ie[g] & cfg.pin_in[g];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_ff <= 5'h00;
      pad_oe_ff <= 5'h00;
      pad_pullup_ff <= 5'h00;
    end else begin
      pad_out_ff <= nxt_out;
      pad_oe_ff <= nxt_oe;
      pad_pullup_ff <= cfg.pu & ~nxt_oe;
    end
  end

  a_oe_follows_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg.fsel[2] && !cfg.od[2]) |=> pad_oe_ff[2] == $past(cfg.oe[2]))
    else $error("pad oe does not follow output enable");
  a_trace_clock_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.fsel[0] |=> (pad_oe_ff[0] && pad_out_ff[0] == $past(trace_clock_out)))
    else $error("trace clock not on pin0");
  a_open_drain_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg.fsel[3] && cfg.od[3] && cfg.data[3]) |=> !pad_oe_ff[3])
    else $error("open-drain pin drives high");
  a_input_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg.ie[1] |-> cfg.rd_in[1] == 1'b0)
    else $error("disabled input not zero");
endmodule : gpio_pad_mux
`default_nettype wire

// [gpio_port_top.sv]
// five-pin port: axi4-lite registers, input sync, pad mux
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output logic [4:0] pin_pullup,
  input wire logic trace_clock_out,
  input wire logic [3:0] trace_data
);
  gpio_pin_if cfg ();

  logic [4:0] data_ff;
  logic [4:0] oe_ff;
  logic [4:0] fsel_ff;
  logic [4:0] od_ff;
  logic [4:0] pu_ff;
  logic [4:0] ie_ff;
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic wr_go;
  logic rd_go;
  logic [11:0] wr_ofs;

  // 4 KiB window; bits above the offset are decoded by the interconnect
  function automatic logic [2:0] decode(input logic [11:0] ofs);
    case (ofs)
      gpio_port_pkg::PIN_DATA_OFS: decode = 3'h0;
      gpio_port_pkg::OUTPUT_ENABLE_CTL_OFS: decode = 3'h1;
      gpio_port_pkg::FUNCTION_SELECT_OFS: decode = 3'h2;
      gpio_port_pkg::OPEN_DRAIN_CTL_OFS: decode = 3'h3;
      gpio_port_pkg::PULLUP_CTL_OFS: decode = 3'h4;
      gpio_port_pkg::INPUT_ENABLE_CTL_OFS: decode = 3'h5;
      default: decode = 3'h7;
    endcase
  endfunction : decode

  // pins are asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // write channel: address and data taken in either order
  assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_ofs = {awaddr_ff[11:2], 2'h0};
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gpio_port_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (decode(wr_ofs) == 3'h7) ? gpio_port_pkg::RESP_SLVERR
                                              : gpio_port_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ff <= gpio_port_pkg::REG_RESET;
      oe_ff <= gpio_port_pkg::REG_RESET;
      fsel_ff <= gpio_port_pkg::REG_RESET;
      od_ff <= gpio_port_pkg::REG_RESET;
      pu_ff <= gpio_port_pkg::REG_RESET;
      ie_ff <= gpio_port_pkg::REG_RESET;
    end else if (wr_go && wstrb_ff[0]) begin
      case (decode(wr_ofs))
        3'h0: data_ff <= wdata_ff[4:0];
        3'h1: oe_ff <= wdata_ff[4:0];
        3'h2: fsel_ff <= wdata_ff[4:0];
        3'h3: od_ff <= wdata_ff[4:0];
        3'h4: pu_ff <= wdata_ff[4:0];
        3'h5: ie_ff <= wdata_ff[4:0];
        default: ;
      endcase
    end
  end

  // read channel: one outstanding read, answered the cycle after arrival
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= gpio_port_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= gpio_port_pkg::RESP_OKAY;
      case (decode({s_axi_araddr[11:2], 2'h0}))
        // data reads back the gated pin level, upper bits zero
        3'h0: s_axi_rdata <= {27'h0, cfg.rd_in};
        3'h1: s_axi_rdata <= {27'h0, oe_ff};
        3'h2: s_axi_rdata <= {27'h0, fsel_ff};
        3'h3: s_axi_rdata <= {27'h0, od_ff};
        3'h4: s_axi_rdata <= {27'h0, pu_ff};
        3'h5: s_axi_rdata <= {27'h0, ie_ff};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= gpio_port_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign cfg.data = data_ff;
  assign cfg.oe = oe_ff;
  assign cfg.fsel = fsel_ff;
  assign cfg.od = od_ff;
  assign cfg.pu = pu_ff;
  assign cfg.ie = ie_ff;
  assign cfg.pin_in = sync2_ff;

  gpio_pad_mux u_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg),
    .trace_clock_out(trace_clock_out),
    .trace_data(trace_data),
    .pad_out_ff(pin_out),
    .pad_oe_ff(pin_oe),
    .pad_pullup_ff(pin_pullup)
  );

  a_reset_all_off: assert property (@(posedge aclk)
    !aresetn |=> (pin_oe == 5'h00 && pin_pullup == 5'h00))
    else $error("pins not released after reset");
  a_write_oe_reg: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && wstrb_ff[0] && wr_ofs == gpio_port_pkg::OUTPUT_ENABLE_CTL_OFS)
    |=> oe_ff == $past(wdata_ff[4:0]))
    else $error("output enable write lost");
  a_read_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("upper read bits nonzero");
  a_gpio_data_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (!fsel_ff[4] && !od_ff[4] && oe_ff[4]) |=> pin_out[4] == $past(data_ff[4]))
    else $error("gpio pin not driven from data");
  a_bresp_one: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");

  c_write_done: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_trace_mode: cover property (@(posedge aclk) fsel_ff == 5'h1F);
  c_open_drain: cover property (@(posedge aclk) od_ff != 5'h00 && oe_ff != 5'h00);
endmodule : gpio_port_top
`default_nettype wire

// [pin_world.sv]
// external pad levels and debug trace source facing the port
`timescale 1ns/10ps
`default_nettype none
module pin_world (
  input wire logic aclk,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] pin_pullup,
  input wire logic [4:0] ext_en,
  input wire logic [4:0] ext_val,
  input wire logic [4:0] trace_pat,
  output logic [4:0] pin_in,
  output logic trace_clock_out,
  output logic [3:0] trace_data
);
  logic flip_ff;
  initial flip_ff = 1'b0;
  // a floating pad flips every cycle so a stale level never passes
  always @(posedge aclk) flip_ff <= !flip_ff;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = flip_ff ^ i[0];
    end
  end
  assign trace_clock_out = trace_pat[0];
  assign trace_data = trace_pat[4:1];
endmodule : pin_world
`default_nettype wire

// [testbench.sv]
// self-checking bench for the five-pin port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tclk;
  logic [1:0] bresp, rresp, r;
  logic [4:0] pin_in, pin_out, pin_oe, pin_pullup;
  logic [4:0] ext_en = '0, ext_val = '0, trace_pat = '0;
  logic [3:0] tdata;
  logic [31:0] v;
  int bad_count = 0, n_compared = 0;
  logic [11:0] ofs [5] = '{gpio_port_pkg::OUTPUT_ENABLE_CTL_OFS,
    gpio_port_pkg::FUNCTION_SELECT_OFS, gpio_port_pkg::OPEN_DRAIN_CTL_OFS,
    gpio_port_pkg::PULLUP_CTL_OFS, gpio_port_pkg::INPUT_ENABLE_CTL_OFS};
  always #2 aclk = !aclk;
  gpio_port_top gpio_port_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .trace_clock_out(tclk), .trace_data(tdata));
  pin_world pin_world_i (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .trace_pat(trace_pat), .pin_in(pin_in), .trace_clock_out(tclk),
    .trace_data(tdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    awaddr <= {20'h0, a};
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // one idle edge so a following call never re-raises bready at once
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    araddr <= {20'h0, a};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arready) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // let pad updates from the last write land before looking at pins
  task automatic settle();
    repeat (4) @(posedge aclk);
    #1;
  endtask : settle
  task automatic pins(input logic [4:0] o, input logic [4:0] e);
    settle();
    chk(pin_oe, e);
    chk(pin_out & e, o);
    @(posedge aclk);
  endtask : pins
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({pin_oe, pin_out, pin_pullup}, '0);
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i]);
      chk(v, '0);
      wr(ofs[i], 32'hFFFF_FFF5);
      rd(ofs[i]);
      chk(v, 32'h15);
      wr(ofs[i], 32'h0);
    end
    $display("register test done");
    wr(12'h00C, 32'h1F);
    chk(r, gpio_port_pkg::RESP_SLVERR);
    rd(12'h00C);
    chk({r, v}, {gpio_port_pkg::RESP_SLVERR, 32'h0});
    $display("unmapped test done");
    wr(gpio_port_pkg::PIN_DATA_OFS, 32'hFFFF_FFEA);
    wr(gpio_port_pkg::OUTPUT_ENABLE_CTL_OFS, 32'h1F);
    pins(5'h0A, 5'h1F);
    wr(gpio_port_pkg::OPEN_DRAIN_CTL_OFS, 32'h1F);
    wr(gpio_port_pkg::PULLUP_CTL_OFS, 32'h1F);
    pins(5'h00, 5'h15);
    chk(pin_pullup, 5'h0A);
    $display("output test done");
    trace_pat <= 5'h15;
    wr(gpio_port_pkg::FUNCTION_SELECT_OFS, 32'h1F);
    pins(5'h15, 5'h1F);
    wr(gpio_port_pkg::OUTPUT_ENABLE_CTL_OFS, 32'h0);
    wr(gpio_port_pkg::PULLUP_CTL_OFS, 32'h0);
    wr(gpio_port_pkg::FUNCTION_SELECT_OFS, 32'h02);
    pins(5'h00, 5'h02);
    $display("trace test done");
    wr(gpio_port_pkg::FUNCTION_SELECT_OFS, 32'h0);
    ext_en <= 5'h1F;
    ext_val <= 5'h13;
    rd(gpio_port_pkg::PIN_DATA_OFS);
    chk(v, 32'h0);
    wr(gpio_port_pkg::INPUT_ENABLE_CTL_OFS, 32'h1F);
    settle();
    rd(gpio_port_pkg::PIN_DATA_OFS);
    chk(v, 32'h13);
    wr(gpio_port_pkg::INPUT_ENABLE_CTL_OFS, 32'h05);
    settle();
    rd(gpio_port_pkg::PIN_DATA_OFS);
    chk(v, 32'h01);
    $display("input test done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
